// ---- dv/hpc_port_power_charge_asserts.sv ----
`timescale 1ns/10ps
module hpc_port_power_charge_asserts
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // over-current pins and power switch drive
    input wire logic [3:0] portOvercurrentN,
    input wire logic [3:0] portPowerSwitchChargeStrapOut,
    input wire logic [3:0] portPowerSwitchChargeStrapOe,
    // speed gating, charging and status
    input wire logic [3:0] portSsEnable,
    input wire logic [3:0] portHsEnable,
    input wire logic [11:0] portChargeMode,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic irq
);
    wire [3:0] pw = portPowerSwitchChargeStrapOut;
    wire [3:0] oe = portPowerSwitchChargeStrapOe;
    wire [3:0] ocN = portOvercurrentN;
    wire [2:0] mode0 = portChargeMode[2:0];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_speed_gate;
        portSsEnable != 4'h0 |-> portHsEnable == 4'hf;
    endproperty
    a_speed_gate: assert property (p_speed_gate) else $error("superspeed on without high-speed");
    property p_reset_quiet;
        disable iff (1'b0) !rst_n |=> pw == 4'h0 && oe == 4'h0 && portChargeMode == 12'h0
            && portSsEnable == 4'h0 && portHsEnable == 4'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
    property p_reset_regs;
        disable iff (1'b0) !rst_n |=> !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("state kept through reset");
    // sync chain must delay the cut by at least two flops
    property p_oc_sync;
        ($past(ocN) & ~ocN & pw) != 4'h0 |-> ((pw & ~ocN) != 4'h0) [*3];
    endproperty
    a_oc_sync: assert property (p_oc_sync) else $error("over-current acted on unsynchronised");
    property p_oc_cut;
        ($past(ocN) & ~ocN & pw) != 4'h0 |-> ##[1:8] (pw & ~ocN) == 4'h0;
    endproperty
    a_oc_cut: assert property (p_oc_cut) else $error("faulted port still powered");
    // strap is read before the pin is driven
    property p_oe_release;
        $rose(rst_n) |-> oe == 4'h0 ##1 oe == 4'h0 ##1 oe == 4'hf;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("pin drive timing wrong");
    property p_mode_legal;
        portChargeMode[2:0] <= 3'h5 && portChargeMode[5:3] <= 3'h5
            && portChargeMode[8:6] <= 3'h5 && portChargeMode[11:9] <= 3'h5;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal charge mode");
    property p_divider_order;
        $changed(mode0) && !($past(mode0) inside {3'h2, 3'h3}) |-> !(mode0 inside {3'h3, 3'h4});
    endproperty
    a_divider_order: assert property (p_divider_order) else $error("divider step skipped");

    c_oc_cut: cover property (($past(ocN) & ~ocN & pw) != 4'h0);
    c_div3: cover property (mode0 == 3'h2);
    c_irq: cover property ($rose(irq));
endmodule

bind hpc_port_power_charge hpc_port_power_charge_asserts u_asserts
(
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .portOvercurrentN(portOvercurrentN),
    .portPowerSwitchChargeStrapOut(portPowerSwitchChargeStrapOut),
    .portPowerSwitchChargeStrapOe(portPowerSwitchChargeStrapOe),
    .portSsEnable(portSsEnable),
    .portHsEnable(portHsEnable),
    .portChargeMode(portChargeMode),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_rvalid(s_axi_rvalid),
    .irq(irq)
);

// ---- dv/hpc_switch_model.sv ----
`timescale 1ns/10ps
module hpc_switch_model
(
    // strap resistor and fault request
    input wire logic [3:0] strap,
    input wire logic [3:0] fault,
    // hub side of the switch
    input wire logic [3:0] pwrOut,
    input wire logic [3:0] pwrOe,
    output logic [3:0] pinLevel,
    output logic [3:0] ocN
);
    // undriven pin settles to the strap resistor level
    assign pinLevel = (pwrOe & pwrOut) | (~pwrOe & strap);
    // flag pulled low only while the switch sees a fault
    assign ocN = ~fault;
endmodule

// ---- dv/test_hub_port_power_charge_ctrl.sv ----
`timescale 1ns/10ps
module test_hub_port_power_charge_ctrl;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [31:0] wData = 32'h0, rd;
    logic [3:0] strap = 4'h0, fault = 4'h0;
    logic [1:0] rsp;
    wire awReady, wReady, bValid, arReady, rValid, irq;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    wire [3:0] pwrOut, pwrOe, pinLevel, ocN, ssEn, hsEn;
    wire [11:0] chgMode;
    int errors = 0, n_compared = 0, cycles = 0;
    int mReq, mOc, mRem, mPwr, mChg, mCtrl, k;
    logic [31:0] ctrlTab [5] = '{32'h8, 32'h2, 32'h0, 32'hc, 32'h18};

    hpc_port_power_charge DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .portPowerSwitchChargeStrapIn(pinLevel), .portPowerSwitchChargeStrapOut(pwrOut),
        .portPowerSwitchChargeStrapOe(pwrOe), .portOvercurrentN(ocN), .portSsEnable(ssEn),
        .portHsEnable(hsEn), .portChargeMode(chgMode), .irq(irq));
    hpc_switch_model u_switch (.strap(strap), .fault(fault), .pwrOut(pwrOut), .pwrOe(pwrOe),
        .pinLevel(pinLevel), .ocN(ocN));

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic int npwr();
        if (!mCtrl[0])
            return mReq & ~mOc & 15;
        if (mOc != 0)
            return 0;
        if (mReq != 0)
            return 15;
        return (mRem == 15) ? 0 : mPwr;
    endfunction

    function automatic logic [31:0] expObs();
        int m;
        logic [11:0] cm;
        m = mCtrl[3] ? 1 : (mCtrl[1] ? 2 : 5);
        for (int i = 0; i < 4; i++)
            cm[3*i+:3] = mChg[i] ? m[2:0] : 3'h0;
        return {8'h0, (mCtrl[2] || mCtrl[4]) ? 4'h0 : 4'hf, mCtrl[2] ? 4'h0 : 4'hf, cm, mPwr[3:0]};
    endfunction

    task automatic mreset();
        mCtrl = int'(hpc_pkg::CTRL_RESET);
        mReq = 0;
        mOc = 0;
        mRem = 15;
        mPwr = 0;
        mChg = strap;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aDone;
        logic dDone;
        @(posedge clk_sys);
        aDone = 1'b0;
        dDone = 1'b0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aDone && dDone))
        begin
            @(posedge clk_sys);
            aDone = aDone || awReady;
            dDone = dDone || wReady;
            if (awReady)
                awValid <= 1'b0;
            if (wReady)
                wValid <= 1'b0;
        end
        do @(posedge clk_sys); while (!bValid);
        bReady <= 1'b0;
        rsp = bResp;
        case (a)
            hpc_pkg::REG_CTRL: mCtrl = int'(d);
            hpc_pkg::REG_PORT_REQ:
            begin
                mOc = mOc & int'(d);
                mReq = int'(d) & 15;
            end
            hpc_pkg::REG_CHARGE_EN: mChg = int'(d);
            hpc_pkg::REG_REMOVABLE: mRem = int'(d);
            default: ;
        endcase
        mPwr = npwr();
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk_sys); while (!arReady);
        arValid <= 1'b0;
        do @(posedge clk_sys); while (!rValid);
        rReady <= 1'b0;
        rd = rData;
        rsp = rResp;
    endtask

    // polls a registered output for a bounded time, then compares
    task automatic settle(input int sel, input logic [31:0] exp);
        logic [31:0] seen;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_sys);
            seen = sel ? {31'h0, irq} : {8'h0, ssEn, hsEn, chgMode, pwrOut};
            if (seen === exp)
                break;
        end
        chk(seen, exp);
    endtask

    initial
    begin
        void'($urandom(27));
        strap <= 4'($urandom_range(15));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        mreset();
        rdr(hpc_pkg::REG_CTRL);
        chk(rd, hpc_pkg::CTRL_RESET);
        rdr(hpc_pkg::REG_REMOVABLE);
        chk(rd, 32'hf);
        rdr(hpc_pkg::REG_CHARGE_EN);
        chk(rd, {28'h0, strap});
        rdr(8'h20);
        chk(rd | {30'h0, rsp}, 32'h2);
        wr(8'h20, 32'h0);
        chk(rsp, 32'h2);
        settle(0, expObs());
        $display("test defaults done");
        for (int i = 0; i < 3; i++)
        begin
            wr(hpc_pkg::REG_PORT_REQ, $urandom_range(15));
            settle(0, expObs());
        end
        wr(hpc_pkg::REG_INT_CLEAR, 32'h1f);
        wr(hpc_pkg::REG_PORT_REQ, 32'hf);
        k = $urandom_range(3);
        fault <= 4'h1 << k;
        mOc = 1 << k;
        mPwr = npwr();
        settle(0, expObs());
        rdr(hpc_pkg::REG_INT_STATUS);
        chk(rd & 32'hf, 32'h1 << k);
        wr(hpc_pkg::REG_INT_ENABLE, ~(32'h1 << k) & 32'hf);
        settle(1, 32'h0);
        wr(hpc_pkg::REG_INT_ENABLE, 32'h1 << k);
        settle(1, 32'h1);
        wr(hpc_pkg::REG_INT_CLEAR, 32'h1 << k);
        settle(1, 32'h0);
        fault <= 4'h0;
        wr(hpc_pkg::REG_PORT_REQ, 32'hf ^ (32'h1 << k));
        wr(hpc_pkg::REG_PORT_REQ, 32'hf);
        settle(0, expObs());
        $display("test individual power done");
        wr(hpc_pkg::REG_PORT_REQ, 32'h0);
        wr(hpc_pkg::REG_CTRL, 32'h9);
        wr(hpc_pkg::REG_PORT_REQ, 32'h1);
        settle(0, expObs());
        wr(hpc_pkg::REG_REMOVABLE, 32'he);
        wr(hpc_pkg::REG_PORT_REQ, 32'h0);
        settle(0, expObs());
        rdr(hpc_pkg::REG_STATUS);
        chk(rd & 32'hf, 32'hf);
        wr(hpc_pkg::REG_REMOVABLE, 32'hf);
        settle(0, expObs());
        wr(hpc_pkg::REG_PORT_REQ, 32'h2);
        settle(0, expObs());
        fault <= 4'h8;
        mOc = 8;
        mPwr = npwr();
        settle(0, expObs());
        fault <= 4'h0;
        wr(hpc_pkg::REG_PORT_REQ, 32'h0);
        $display("test ganged power done");
        for (int i = 0; i < 5; i++)
        begin
            wr(hpc_pkg::REG_CHARGE_EN, $urandom_range(15) | 1);
            wr(hpc_pkg::REG_CTRL, ctrlTab[i]);
            settle(0, expObs());
        end
        $display("test speed and charging done");
        rst_n <= 1'b0;
        strap <= ~strap;
        repeat (2) @(posedge clk_sys);
        chk({8'h0, ssEn, hsEn, chgMode, pwrOut | pwrOe}, 32'h0);
        rst_n <= 1'b1;
        mreset();
        rdr(hpc_pkg::REG_CHARGE_EN);
        chk(rd, {28'h0, strap});
        rdr(hpc_pkg::REG_CTRL);
        chk(rd, hpc_pkg::CTRL_RESET);
        settle(0, expObs());
        $display("test second reset done");
        report_and_stop();
    end
endmodule

// ---- logic/hpc_axil_slave.sv ----
`timescale 1ns/10ps
module hpc_axil_slave
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register access strobes
    output logic wrStb,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdHit,
    input wire logic wrHit
);

    logic awHave_r;
    logic wHave_r;
    logic arHave_r;

    assign wrStb = awHave_r && wHave_r && !s_axi_bvalid;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            wrAddr <= 8'h00;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_r <= 1'b1;
                s_axi_awready <= 1'b0;
                wrAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end
            if (wrStb)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? 2'h0 : 2'h2;
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            arHave_r <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
            rdAddr <= 8'h00;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                arHave_r <= 1'b1;
                s_axi_arready <= 1'b0;
                rdAddr <= s_axi_araddr;
            end
            if (arHave_r)
            begin
                arHave_r <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdData;
                s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ---- logic/hpc_oc_sync.sv ----
`timescale 1ns/10ps
module hpc_oc_sync
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // asynchronous input and synchronised output
    input wire logic ocRawN,
    output logic ocSyncN
);

    logic stage1_r;

    // two flops; first stage feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stage1_r <= 1'b1;
            ocSyncN <= 1'b1;
        end
        else
        begin
            stage1_r <= ocRawN;
            ocSyncN <= stage1_r;
        end
    end

endmodule

// ---- logic/hpc_pkg.sv ----
package hpc_pkg;

    localparam int NUM_PORTS = 4;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PORT_REQ = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_STATUS = 8'h0c;
    localparam logic [7:0] REG_INT_ENABLE = 8'h10;
    localparam logic [7:0] REG_INT_CLEAR = 8'h14;
    localparam logic [7:0] REG_CHARGE_EN = 8'h18;
    localparam logic [7:0] REG_REMOVABLE = 8'h1c;

    // control register fields
    localparam int CTRL_GANGED_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_FS_ONLY_BIT = 2;
    localparam int CTRL_UP_CONN_BIT = 3;
    localparam int CTRL_HS_ONLY_BIT = 4;

    // status register fields
    localparam int STAT_POWER_LSB = 0;
    localparam int STAT_OC_LSB = 4;
    localparam int STAT_MODE_LSB = 8;
    localparam int STAT_SS_LSB = 12;
    localparam int STAT_HS_LSB = 16;

    // interrupt status fields: over-current per port, then mode change
    localparam int INT_OC_LSB = 0;
    localparam int INT_MODE_BIT = 4;
    localparam int INT_WIDTH = 5;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
    localparam logic [3:0] REMOVABLE_RESET = 4'hf;

    // dwell time per divider mode in automatic sequence
    localparam int CLK_MHZ = 100;
    localparam int DWELL_MS = 2;
    localparam int DWELL_CYCLES = DWELL_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0]
    {
        CHG_OFF,
        CHG_HSHK,
        CHG_DIV3,
        CHG_DIV2,
        CHG_DIV1,
        CHG_DED
    } hpc_charge_mode_t;

endpackage

// ---- logic/hpc_port_power_charge.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Full/low-speed-only upstream link disables SuperSpeed and high-speed on all ports.
// - Individual mode: each port power follows its own host request.
// - Individual mode: over-current on a port removes only that port's power.
// - Ganged mode: all ports powered when any port needs power.
// - Ganged mode: power stays on until every port allows removal.
// - Ganged mode: any over-current switches all ports off.
// - Upstream connected: charging-enabled ports run the charging downstream port handshake.
// - Upstream unconnected: charging ports may run dedicated charging mode.
// - Automatic unconnected: step divider modes from three, end in dedicated charging.
// - Per-port charging support selectable by strap, or by software.
// - Global reset returns all internal registers to defaults.
// - During global reset no port power and no charging mode.
// - Strap pin sampled at reset release; 1 enables charging, 0 disables.
module hpc_port_power_charge
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // power switch pins, shared with charge strap
    input wire logic [3:0] portPowerSwitchChargeStrapIn,
    output logic [3:0] portPowerSwitchChargeStrapOut,
    output logic [3:0] portPowerSwitchChargeStrapOe,
    input wire logic [3:0] portOvercurrentN,
    // downstream speed gating and charging modes
    output logic [3:0] portSsEnable,
    output logic [3:0] portHsEnable,
    output logic [11:0] portChargeMode,
    // interrupt
    output logic irq
);

    localparam int NP = hpc_pkg::NUM_PORTS;
    localparam int DWELL = hpc_pkg::DWELL_CYCLES;

    logic [3:0] ocSyncN;
    logic wrStb;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic rdHit;
    logic wrHit;

    logic [31:0] ctrl_r;
    logic [3:0] portReq_r;
    logic [3:0] removable_r;
    logic [3:0] chargeEn_r;
    logic strapPending_r;
    logic [3:0] ocLatch_r;
    logic [3:0] power_r;
    logic [3:0] power_nxt;
    logic [hpc_pkg::INT_WIDTH-1:0] intStatus_r;
    logic [hpc_pkg::INT_WIDTH-1:0] intEnable_r;
    logic [hpc_pkg::INT_WIDTH-1:0] intSet;
    logic [hpc_pkg::INT_WIDTH-1:0] intClr;
    hpc_pkg::hpc_charge_mode_t mode_r;
    hpc_pkg::hpc_charge_mode_t mode_nxt;
    logic [31:0] dwell_r;
    logic modeChange;

    logic ganged;
    logic autoMode;
    logic upConn;
    assign ganged = ctrl_r[hpc_pkg::CTRL_GANGED_BIT];
    assign autoMode = ctrl_r[hpc_pkg::CTRL_AUTO_BIT];
    assign upConn = ctrl_r[hpc_pkg::CTRL_UP_CONN_BIT];

    genvar g;
    generate
        for (g = 0; g < NP; g++)
        begin : gSync
            hpc_oc_sync uSync
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .ocRawN(portOvercurrentN[g]),
                .ocSyncN(ocSyncN[g])
            );
        end
    endgenerate

    hpc_axil_slave uBus
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrStb(wrStb),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdHit(rdHit),
        .wrHit(wrHit)
    );

    // write decode
    always_comb
    begin
        unique case (wrAddr)
            hpc_pkg::REG_CTRL, hpc_pkg::REG_PORT_REQ, hpc_pkg::REG_INT_ENABLE,
            hpc_pkg::REG_INT_CLEAR, hpc_pkg::REG_CHARGE_EN, hpc_pkg::REG_REMOVABLE:
                wrHit = 1'b1;
            default:
                wrHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_r <= hpc_pkg::CTRL_RESET;
            portReq_r <= 4'h0;
            removable_r <= hpc_pkg::REMOVABLE_RESET;
            intEnable_r <= '0;
        end
        else if (wrStb && wrStrb[0])
        begin
            unique case (wrAddr)
                hpc_pkg::REG_CTRL: ctrl_r <= {27'h0, wrData[4:0]};
                hpc_pkg::REG_PORT_REQ: portReq_r <= wrData[3:0];
                hpc_pkg::REG_REMOVABLE: removable_r <= wrData[3:0];
                hpc_pkg::REG_INT_ENABLE: intEnable_r <= wrData[hpc_pkg::INT_WIDTH-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // strap caught on the first clock after reset release, software may override later
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            strapPending_r <= 1'b1;
            chargeEn_r <= 4'h0;
        end
        else if (strapPending_r)
        begin
            strapPending_r <= 1'b0;
            chargeEn_r <= portPowerSwitchChargeStrapIn;
        end
        else if (wrStb && wrStrb[0] && wrAddr == hpc_pkg::REG_CHARGE_EN)
        begin
            chargeEn_r <= wrData[3:0];
        end
    end

    // over-current latches until host drops the port request
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ocLatch_r <= 4'h0;
        else
            ocLatch_r <= (ocLatch_r & portReq_r) | ~ocSyncN;
    end

    always_comb
    begin
        if (ganged)
        begin
            if (|ocLatch_r)
                power_nxt = 4'h0;
            else if (|portReq_r)
                power_nxt = 4'hf;
            else if (&removable_r)
                power_nxt = 4'h0;
            else
                power_nxt = power_r;
        end
        else
        begin
            power_nxt = portReq_r & ~ocLatch_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            power_r <= 4'h0;
        else
            power_r <= power_nxt;
    end

    // pin is driven only after the strap has been read
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            portPowerSwitchChargeStrapOut <= 4'h0;
            portPowerSwitchChargeStrapOe <= 4'h0;
        end
        else
        begin
            portPowerSwitchChargeStrapOut <= power_nxt;
            portPowerSwitchChargeStrapOe <= {NP{!strapPending_r}};
        end
    end

    // speed gating from upstream link speed
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            portSsEnable <= 4'h0;
            portHsEnable <= 4'h0;
        end
        else if (ctrl_r[hpc_pkg::CTRL_FS_ONLY_BIT])
        begin
            portSsEnable <= 4'h0;
            portHsEnable <= 4'h0;
        end
        else
        begin
            portSsEnable <= ctrl_r[hpc_pkg::CTRL_HS_ONLY_BIT] ? 4'h0 : 4'hf;
            portHsEnable <= 4'hf;
        end
    end

    // charging mode sequencer, shared by all charging-enabled ports
    always_comb
    begin
        mode_nxt = mode_r;
        if (upConn)
            mode_nxt = hpc_pkg::CHG_HSHK;
        else if (!autoMode)
            mode_nxt = hpc_pkg::CHG_DED;
        else
        begin
            unique case (mode_r)
                hpc_pkg::CHG_OFF, hpc_pkg::CHG_HSHK: mode_nxt = hpc_pkg::CHG_DIV3;
                hpc_pkg::CHG_DIV3: if (dwell_r == 32'h0) mode_nxt = hpc_pkg::CHG_DIV2;
                hpc_pkg::CHG_DIV2: if (dwell_r == 32'h0) mode_nxt = hpc_pkg::CHG_DIV1;
                hpc_pkg::CHG_DIV1: if (dwell_r == 32'h0) mode_nxt = hpc_pkg::CHG_DED;
                hpc_pkg::CHG_DED: mode_nxt = hpc_pkg::CHG_DED;
                default: mode_nxt = hpc_pkg::CHG_OFF;
            endcase
        end
    end

    assign modeChange = (mode_nxt != mode_r);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mode_r <= hpc_pkg::CHG_OFF;
            dwell_r <= 32'h0;
        end
        else
        begin
            mode_r <= mode_nxt;
            if (modeChange)
                dwell_r <= 32'(DWELL - 1);
            else if (dwell_r != 32'h0)
                dwell_r <= dwell_r - 32'h1;
        end
    end

    // per-port mode: off unless charging enabled
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            portChargeMode <= 12'h000;
        else
            for (int i = 0; i < NP; i++)
                portChargeMode[i*3 +: 3] <= chargeEn_r[i] ? mode_nxt : hpc_pkg::CHG_OFF;
    end

    // interrupts: set wins over clear
    assign intSet = {modeChange, ~ocSyncN & ~ocLatch_r};
    assign intClr = (wrStb && wrStrb[0] && wrAddr == hpc_pkg::REG_INT_CLEAR) ?
        wrData[hpc_pkg::INT_WIDTH-1:0] : '0;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            intStatus_r <= '0;
        else
            intStatus_r <= (intStatus_r & ~intClr) | intSet;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(((intStatus_r & ~intClr) | intSet) & intEnable_r);
    end

    // read decode
    always_comb
    begin
        rdHit = 1'b1;
        unique case (rdAddr)
            hpc_pkg::REG_CTRL: rdData = ctrl_r;
            hpc_pkg::REG_PORT_REQ: rdData = {28'h0, portReq_r};
            hpc_pkg::REG_STATUS: rdData = {12'h0, portHsEnable, portSsEnable, 1'b0, mode_r, ocLatch_r, power_r};
            hpc_pkg::REG_INT_STATUS: rdData = {27'h0, intStatus_r};
            hpc_pkg::REG_INT_ENABLE: rdData = {27'h0, intEnable_r};
            hpc_pkg::REG_INT_CLEAR: rdData = 32'h0;
            hpc_pkg::REG_CHARGE_EN: rdData = {28'h0, chargeEn_r};
            hpc_pkg::REG_REMOVABLE: rdData = {28'h0, removable_r};
            default:
            begin
                rdData = 32'h0;
                rdHit = 1'b0;
            end
        endcase
    end

endmodule
